// ===== core/vccc_regs.svh
// Purpose: register indices, field positions and reset values of the
//          virtualization control capability bank
// Assumes: indices are model-register numbers, not byte addresses
// Notes:   definitions only
`ifndef VCCC_REGS_SVH
`define VCCC_REGS_SVH

// register indices
`define VCCC_EXIT_CAP_IDX 32'h0000_0483
`define VCCC_ENTRY_CAP_IDX 32'h0000_0484
`define VCCC_MISC_CAP_IDX 32'h0000_0485
`define VCCC_SEC_CAP_IDX 32'h0000_048b
`define VCCC_TEXIT_CAP_IDX 32'h0000_048f
`define VCCC_TENTRY_CAP_IDX 32'h0000_0490
`define VCCC_SMM_BASE_IDX 32'h0000_009e

// reserved-default-one class members of the exit and entry control words
`define VCCC_EXIT_DEF1_MASK 32'h0003_6dff
`define VCCC_ENTRY_DEF1_MASK 32'h0000_11ff

// miscellaneous register field positions
`define VCCC_MISC_RATIO_LSB 0
`define VCCC_MISC_LMA_BIT 5
`define VCCC_MISC_ACT_LSB 6
`define VCCC_MISC_SMBASE_BIT 15
`define VCCC_MISC_CR3_LSB 16
`define VCCC_MISC_LIST_LSB 25
`define VCCC_MISC_SMMMON_BIT 28
`define VCCC_MISC_VMW_BIT 29
`define VCCC_MISC_MONITOR_SEGMENT_LSB 32

// reset values
`define VCCC_RD_DATA_RST 64'h0000_0000_0000_0000
`define VCCC_TIMER_RST 32'h0000_0000

`endif

// ===== core/vccc_pkg.sv
// Purpose: shared types of the capability bank
// Assumes: nothing beyond the register header
// Notes:   types only; constants live in vccc_regs.svh
package vccc_pkg;

    // guest activity states a vm entry may establish
    typedef enum logic [1:0] {
        VCCC_ACT_ACTIVE,
        VCCC_ACT_HALT,
        VCCC_ACT_SHUTDOWN,
        VCCC_ACT_WAIT_STARTUP_INTERPROCESSOR_IRQ
    } vccc_activity_t;

    // control words presented with a vm entry request
    typedef struct packed {
        logic act_sec;
        logic [31:0] sec_ctl;
        logic [31:0] exit_ctl;
        logic [31:0] entry_ctl;
        vccc_activity_t activity;
    } vccc_entry_req_t;

    // reasons for a failed vm entry
    typedef struct packed {
        logic sec;
        logic exits;
        logic entries;
        logic act;
    } vccc_fail_t;

endpackage : vccc_pkg

// ===== core/vccc_ctl_check.sv
// Purpose: checks one control word against its 64-bit capability report
// Assumes: low half = allowed-0 mask, high half = allowed-1 mask
// Notes:   purely combinational; the caller registers the result
`timescale 1ns/1ps
module vccc_ctl_check #(
    parameter int W = 32
) (
    input wire logic [W-1:0] ctl, // control word under test
    input wire logic [2*W-1:0] cap, // capability report
    input wire logic gate, // check applies when high
    output logic fail // word violates report
);
    logic [W-1:0] bad;

    // per bit: a 1 that is not allowed, or a 0 that is forbidden
    for (genvar i = 0; i < W; i++) begin : g_bit
        assign bad[i] = (ctl[i] & ~cap[W+i]) | (~ctl[i] & cap[i]);
    end

    assign fail = gate & (|bad);
endmodule : vccc_ctl_check

// ===== core/vccc_preempt_timer.sv
// Purpose: preemption countdown clocked by a timestamp counter bit
// Assumes: tsc_inc marks the cycle in which tsc_val shows a new count
// Notes:   a bit flip without tsc_inc (a software write) never counts
`timescale 1ns/1ps
`include "vccc_regs.svh"
module vccc_preempt_timer #(
    parameter int W = 32
) (
    input wire logic clk_sys, // core clock
    input wire logic rst_n, // synchronous reset, active low
    input wire logic load, // load a new count
    input wire logic [W-1:0] load_val, // count to load
    input wire logic run, // timer active
    input wire logic tsc_inc, // timestamp counter incremented
    input wire logic [63:0] tsc_val, // timestamp counter value
    input wire logic [4:0] ratio, // selected counter bit
    output logic [W-1:0] count_r, // current count
    output logic expired_r // pulse when count reaches zero
);
    logic tap_r;
    logic tick;

    assign tick = run & tsc_inc & (tsc_val[ratio] != tap_r);

    // remember the selected bit to see it toggle
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            tap_r <= 1'b0;
        end else begin
            tap_r <= tsc_val[ratio];
        end
    end

    // count down one per toggle; load wins over a tick
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            count_r <= W'(`VCCC_TIMER_RST);
            expired_r <= 1'b0;
        end else begin
            expired_r <= 1'b0;
            if (load) begin
                count_r <= load_val;
            end else if (tick && count_r != '0) begin // see [R13]
                count_r <= count_r - W'(1);
                expired_r <= (count_r == W'(1));
            end
        end
    end
endmodule : vccc_preempt_timer

// ===== core/vccc_top.sv
// Purpose: capability registers of the virtualization extension and the
//          vm entry checks that apply them
// Assumes: all inputs synchronous to clk_sys; requests are one-cycle pulses
// Notes:   capabilities are fixed by parameters; writes never alter them
`timescale 1ns/1ps
`include "vccc_regs.svh"

// Operation
// [R1] secondary report low half reads zero
// [R2] secondary 1 needs allowed-1 bit when activated
// [R3] secondary register exists only if primary allows
// [R4] legacy exit report forces default-one bits
// [R5] exit control 0 fails if allowed-0 set
// [R6] basic bit 55 clear: default-one exits 1
// [R7] true exit register only when bit 55 set
// [R8] exit control 1 needs allowed-1 bit
// [R9] legacy entry report forces default-one bits
// [R10] basic bit 55 clear: default-one entries 1
// [R11] entry controls checked against both halves
// [R12] one entry report applies, chosen by bit 55
// [R13] timer decrements on selected counter bit toggle
// [R14] exit copies long mode flag when enabled
// [R15] unsupported activity state fails the entry
// [R16] smm base readable in smm when allowed
// [R17] cr3 target count 0 to 256 encoded
// [R18] software keeps lists within recommended maximum
// [R19] monitor control bit 2 gates smi unblock
// [R20] field writes to exit info need bit 29
// [R21] monitor segment revision in upper half
// [R22] reserved miscellaneous bits read zero
// [R23] default-one class relaxed only under bit 55
// [R24] capability registers are read-only constants
module vccc_top #(
    parameter bit BASIC_TRUE_CTLS = 1'b1, // basic capability bit 55
    parameter bit PRIM_SEC_OK = 1'b1, // primary report bit 63
    parameter logic [31:0] SEC_ALLOWED1 = 32'h0000_00ff,
    parameter logic [31:0] EXIT_ALLOWED0 = 32'h0000_0000,
    parameter logic [31:0] EXIT_TRUE_ALLOWED0 = 32'h0000_0000,
    parameter logic [31:0] EXIT_ALLOWED1 = 32'h003f_ffff,
    parameter logic [31:0] ENTRY_ALLOWED0 = 32'h0000_0000,
    parameter logic [31:0] ENTRY_TRUE_ALLOWED0 = 32'h0000_0000,
    parameter logic [31:0] ENTRY_ALLOWED1 = 32'h0000_ffff,
    parameter logic [4:0] TIMER_RATIO = 5'h05,
    parameter bit LMA_STORE = 1'b1,
    parameter bit UNRESTRICTED = 1'b1,
    parameter logic [2:0] ACT_SUPPORT = 3'h7,
    parameter bit SMBASE_READ = 1'b1,
    parameter int CR3_TARGETS = 4,
    parameter logic [2:0] LIST_N = 3'h0,
    parameter bit SMM_MON_BIT2 = 1'b1,
    parameter bit CONTROL_FIELD_WRITE_INSTR_ALL = 1'b1,
    parameter logic [31:0] MONITOR_SEGMENT_REV = 32'h0000_0001 // arbitrary value
) (
    input wire logic clk_sys, // core clock, 40 mhz
    input wire logic rst_n, // synchronous reset, active low
    input wire logic rd_req, // register read request
    input wire logic wr_req, // register write attempt
    input wire logic [31:0] rd_index, // register index of request
    input wire logic in_smm, // processor is in system management mode
    input wire logic [63:0] smbase_val, // smm base register value
    output logic [63:0] rd_data_r, // read data
    output logic rd_ack_r, // read or write answered
    output logic rd_fault_r, // request refused
    input wire logic entry_req, // vm entry check request
    input wire vccc_pkg::vccc_entry_req_t entry_in, // controls to check
    output logic entry_done_r, // check finished
    output logic entry_fail_r, // entry refused
    output vccc_pkg::vccc_fail_t fail_why_r, // reasons for refusal
    input wire logic tmr_load, // load preemption timer
    input wire logic [31:0] tmr_val, // value to load
    input wire logic tmr_run, // timer active
    input wire logic tsc_inc, // timestamp counter incremented
    input wire logic [63:0] tsc_val, // timestamp counter value
    output logic [31:0] tmr_count_r, // timer count
    output logic tmr_expired_r, // timer reached zero
    input wire logic vm_exit, // vm exit in progress
    input wire logic long_mode_active_flag, // long mode active
    output logic lmg_ctl_r, // long-mode-guest entry control
    input wire logic smm_mon_wr, // write smm monitor control bit 2
    input wire logic smm_mon_wbit, // value for bit 2
    output logic smm_mon_bit2_r, // smm monitor control bit 2
    input wire logic virt_leave_instr, // leaving virtualization
    output logic smi_unblock_r, // pulse: smis unblocked
    input wire logic fw_req, // control field write request
    input wire logic fw_exit_info, // target is an exit-information field
    output logic fw_refuse_r // field write refused
);
    logic [63:0] sec_cap, exit_cap, texit_cap, entry_cap, tentry_cap;
    logic [63:0] misc_cap, exit_use, entry_use;
    logic [8:0] cr3_enc;
    logic sec_bad, exit_bad, entry_bad, act_bad;

    // cr3 target count saturates at 256 so bit 24 is set only alone
    assign cr3_enc = (CR3_TARGETS >= 256) ? 9'h100
                   : 9'(CR3_TARGETS); // see [R17]

    // fixed capability words; no storage, so writes cannot reach them
    assign sec_cap = {SEC_ALLOWED1, 32'h0000_0000}; // see [R1] see [R24]
    assign exit_cap = {EXIT_ALLOWED1,
                       EXIT_ALLOWED0 | `VCCC_EXIT_DEF1_MASK}; // see [R4]
    assign texit_cap = {EXIT_ALLOWED1, EXIT_TRUE_ALLOWED0}; // see [R7]
    assign entry_cap = {ENTRY_ALLOWED1,
                        ENTRY_ALLOWED0 | `VCCC_ENTRY_DEF1_MASK}; // see [R9]
    assign tentry_cap = {ENTRY_ALLOWED1, ENTRY_TRUE_ALLOWED0};
    assign misc_cap = {MONITOR_SEGMENT_REV, 2'h0, CONTROL_FIELD_WRITE_INSTR_ALL, SMM_MON_BIT2, LIST_N,
                       cr3_enc, SMBASE_READ, 6'h00, ACT_SUPPORT,
                       LMA_STORE | UNRESTRICTED, TIMER_RATIO};
    // see [R21] see [R22] see [R14]

    // bit 55 picks which report governs the default-one class
    assign exit_use = BASIC_TRUE_CTLS ? texit_cap : exit_cap; // see [R6]
    assign entry_use = BASIC_TRUE_CTLS ? tentry_cap : entry_cap;
    // see [R10] see [R12] see [R23]

    vccc_ctl_check #(.W(32)) u_sec_chk (
        .ctl(entry_in.sec_ctl),
        .cap(sec_cap),
        .gate(entry_in.act_sec & PRIM_SEC_OK), // see [R2]
        .fail(sec_bad)
    );

    vccc_ctl_check #(.W(32)) u_exit_chk (
        .ctl(entry_in.exit_ctl),
        .cap(exit_use), // see [R5] see [R8]
        .gate(1'b1),
        .fail(exit_bad)
    );

    vccc_ctl_check #(.W(32)) u_entry_chk (
        .ctl(entry_in.entry_ctl),
        .cap(entry_use), // see [R11]
        .gate(1'b1),
        .fail(entry_bad)
    );

    // state 0 is always accepted; others need their support bit
    always_comb begin
        unique case (entry_in.activity)
            vccc_pkg::VCCC_ACT_ACTIVE: act_bad = 1'b0;
            vccc_pkg::VCCC_ACT_HALT: act_bad = ~ACT_SUPPORT[0];
            vccc_pkg::VCCC_ACT_SHUTDOWN: act_bad = ~ACT_SUPPORT[1];
            vccc_pkg::VCCC_ACT_WAIT_STARTUP_INTERPROCESSOR_IRQ: act_bad = ~ACT_SUPPORT[2];
        endcase // see [R15]
    end

    // entry verdict answers one cycle after the request
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            entry_done_r <= 1'b0;
            entry_fail_r <= 1'b0;
            fail_why_r <= '0;
        end else begin
            entry_done_r <= entry_req;
            if (entry_req) begin
                fail_why_r <= '{sec: sec_bad, exits: exit_bad,
                                entries: entry_bad, act: act_bad};
                entry_fail_r <= sec_bad | exit_bad | entry_bad | act_bad;
            end
        end
    end

    // register reads; absent registers and all writes are refused
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rd_data_r <= `VCCC_RD_DATA_RST;
            rd_ack_r <= 1'b0;
            rd_fault_r <= 1'b0;
        end else begin
            rd_ack_r <= rd_req | wr_req;
            rd_fault_r <= 1'b0;
            rd_data_r <= `VCCC_RD_DATA_RST;
            if (wr_req) begin
                rd_fault_r <= 1'b1; // see [R24]
            end else if (rd_req) begin
                unique case (rd_index)
                    `VCCC_EXIT_CAP_IDX: rd_data_r <= exit_cap;
                    `VCCC_ENTRY_CAP_IDX: rd_data_r <= entry_cap;
                    `VCCC_MISC_CAP_IDX: rd_data_r <= misc_cap;
                    `VCCC_SEC_CAP_IDX: begin
                        if (PRIM_SEC_OK) rd_data_r <= sec_cap;
                        else rd_fault_r <= 1'b1; // see [R3]
                    end
                    `VCCC_TEXIT_CAP_IDX: begin
                        if (BASIC_TRUE_CTLS) rd_data_r <= texit_cap;
                        else rd_fault_r <= 1'b1; // see [R7]
                    end
                    `VCCC_TENTRY_CAP_IDX: begin
                        if (BASIC_TRUE_CTLS) rd_data_r <= tentry_cap;
                        else rd_fault_r <= 1'b1; // see [R12]
                    end
                    `VCCC_SMM_BASE_IDX: begin
                        if (in_smm && SMBASE_READ) rd_data_r <= smbase_val;
                        else rd_fault_r <= 1'b1; // see [R16]
                    end
                    default: rd_fault_r <= 1'b1;
                endcase
            end
        end
    end

    vccc_preempt_timer #(.W(32)) u_timer (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .load(tmr_load),
        .load_val(tmr_val),
        .run(tmr_run),
        .tsc_inc(tsc_inc),
        .tsc_val(tsc_val),
        .ratio(TIMER_RATIO), // see [R13]
        .count_r(tmr_count_r),
        .expired_r(tmr_expired_r)
    );

    // exit copies the long mode flag only when the report says so
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            lmg_ctl_r <= 1'b0;
        end else if (vm_exit && misc_cap[`VCCC_MISC_LMA_BIT]) begin
            lmg_ctl_r <= long_mode_active_flag; // see [R14]
        end
    end

    // monitor bit 2 sticks at 0 where unsupported; it keeps smis blocked
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            smm_mon_bit2_r <= 1'b0;
            smi_unblock_r <= 1'b0;
        end else begin
            if (smm_mon_wr) begin
                smm_mon_bit2_r <= smm_mon_wbit & SMM_MON_BIT2; // see [R19]
            end
            smi_unblock_r <= virt_leave_instr & ~smm_mon_bit2_r;
        end
    end

    // exit-information fields are read-only unless bit 29 is set
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            fw_refuse_r <= 1'b0;
        end else begin
            fw_refuse_r <= fw_req & fw_exit_info & ~CONTROL_FIELD_WRITE_INSTR_ALL; // see [R20]
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sec_low_zero_a: assert property ( // see [R1]
        rd_req && !wr_req && rd_index == `VCCC_SEC_CAP_IDX && PRIM_SEC_OK
        |=> rd_ack_r && rd_data_r[31:0] == 32'h0000_0000)
        else $error("secondary report low half not zero");

    sec_fail_a: assert property ( // see [R2]
        entry_req && entry_in.act_sec && PRIM_SEC_OK
        && |(entry_in.sec_ctl & ~SEC_ALLOWED1)
        |=> entry_done_r && entry_fail_r && fail_why_r.sec)
        else $error("disallowed secondary control accepted");

    exit_def1_a: assert property ( // see [R4]
        rd_req && !wr_req && rd_index == `VCCC_EXIT_CAP_IDX
        |=> (rd_data_r[31:0] & `VCCC_EXIT_DEF1_MASK)
            == `VCCC_EXIT_DEF1_MASK)
        else $error("exit default-one bits not read as 1");

    entry_def1_a: assert property ( // see [R9]
        rd_req && !wr_req && rd_index == `VCCC_ENTRY_CAP_IDX
        |=> (rd_data_r[31:0] & `VCCC_ENTRY_DEF1_MASK)
            == `VCCC_ENTRY_DEF1_MASK)
        else $error("entry default-one bits not read as 1");

    legacy_def1_a: assert property ( // see [R6]
        entry_req && !BASIC_TRUE_CTLS
        && |(~entry_in.exit_ctl & `VCCC_EXIT_DEF1_MASK)
        |=> entry_fail_r && fail_why_r.exits)
        else $error("cleared default-one exit control accepted");

    true_absent_a: assert property ( // see [R12]
        rd_req && !wr_req && !BASIC_TRUE_CTLS
        && (rd_index == `VCCC_TEXIT_CAP_IDX
            || rd_index == `VCCC_TENTRY_CAP_IDX)
        |=> rd_ack_r && rd_fault_r)
        else $error("true report read while unsupported");

    misc_fields_a: assert property ( // see [R22]
        rd_req && !wr_req && rd_index == `VCCC_MISC_CAP_IDX
        |=> rd_data_r[14:9] == 6'h00 && rd_data_r[31:30] == 2'h0
            && rd_data_r[24] == (rd_data_r[23:16] == 8'h00)
            && rd_data_r[63:32] == MONITOR_SEGMENT_REV)
        else $error("miscellaneous report fields wrong");

    act_fail_a: assert property ( // see [R15]
        entry_req && entry_in.activity == vccc_pkg::VCCC_ACT_ACTIVE
        |=> !fail_why_r.act)
        else $error("active state refused");

    write_refused_a: assert property ( // see [R24]
        wr_req |=> rd_ack_r && rd_fault_r
        && rd_data_r == `VCCC_RD_DATA_RST)
        else $error("write to capability register not refused");

    timer_step_a: assert property ( // see [R13]
        !tmr_load && !tmr_run |=> $stable(tmr_count_r))
        else $error("inactive timer moved");

    lmg_copy_a: assert property ( // see [R14]
        vm_exit && (LMA_STORE || UNRESTRICTED)
        |=> lmg_ctl_r == $past(long_mode_active_flag))
        else $error("long mode flag not copied on exit");

    smi_gate_a: assert property ( // see [R19]
        virt_leave_instr |=> smi_unblock_r == !$past(smm_mon_bit2_r))
        else $error("smi unblock ignores monitor bit 2");

    fw_gate_a: assert property ( // see [R20]
        fw_req && fw_exit_info && !CONTROL_FIELD_WRITE_INSTR_ALL |=> fw_refuse_r)
        else $error("exit-information write allowed");

    entry_ok_c: cover property (entry_req ##1 entry_done_r && !entry_fail_r);
    entry_bad_c: cover property (entry_req ##1 entry_fail_r);
    rd_misc_c: cover property (rd_req && rd_index == `VCCC_MISC_CAP_IDX);
    tmr_exp_c: cover property (tmr_expired_r);
endmodule : vccc_top

// ===== verif/vccc_top_tb.sv
// Purpose: self-checking bench for the capability bank and its entry checks
// Assumes: one clock at 40 mhz; every answer lands one cycle after its cause
// Notes:   a second bank with bit 55 clear covers the legacy path and
//          the refusals that the main bank never shows
`timescale 1ns/1ps
`include "vccc_regs.svh"
module vccc_top_tb;
    localparam logic [31:0] SEC_A1 = 32'h0000_00ff;
    localparam logic [31:0] EXIT_A1 = 32'h003f_ffff;
    localparam logic [31:0] EXIT_TA0 = 32'h0000_0004;
    localparam logic [31:0] ENTRY_A1 = 32'h0000_ffff;
    localparam logic [31:0] ENTRY_TA0 = 32'h0000_0200;
    localparam logic [2:0] ACT_SUP = 3'h5; // shutdown left unsupported
    localparam logic [2:0] LIST = 3'h2;
    localparam logic [31:0] MONITOR_SEGMENT = 32'h0000_00a5; // arbitrary value
    localparam logic [63:0] MISC_EXP = {MONITOR_SEGMENT, 2'h0, 1'b1, 1'b1, LIST,
        9'h004, 1'b1, 6'h00, ACT_SUP, 1'b1, 5'h05};
    logic clk_sys, rst_n, rd_req, wr_req, in_smm, entry_req;
    logic [31:0] rd_index, tmr_val;
    logic [63:0] smbase_val, tsc_val, rd_data_r;
    logic rd_ack_r, rd_fault_r, entry_done_r, entry_fail_r;
    vccc_pkg::vccc_entry_req_t entry_in;
    vccc_pkg::vccc_fail_t fail_why_r;
    logic tmr_load, tmr_run, tsc_inc, tmr_expired_r, vm_exit, lma;
    logic [31:0] tmr_count_r;
    logic lmg_ctl_r, smm_mon_wr, smm_mon_wbit, smm_mon_bit2_r, leave;
    logic smi_unblock_r, fw_req, fw_exit_info, fw_refuse_r;
    logic lg_ack, lg_flt, lg_fw;
    vccc_pkg::vccc_fail_t lg_why;
    int err_count = 0;
    int checks = 0;

    vccc_top #(.EXIT_TRUE_ALLOWED0(EXIT_TA0), .ENTRY_TRUE_ALLOWED0(ENTRY_TA0),
        .ACT_SUPPORT(ACT_SUP), .CR3_TARGETS(4), .LIST_N(LIST),
        .MONITOR_SEGMENT_REV(MONITOR_SEGMENT), .TIMER_RATIO(5'h05)) DUT (
        .clk_sys(clk_sys), .rst_n(rst_n), .rd_req(rd_req), .wr_req(wr_req),
        .rd_index(rd_index), .in_smm(in_smm), .smbase_val(smbase_val),
        .rd_data_r(rd_data_r), .rd_ack_r(rd_ack_r), .rd_fault_r(rd_fault_r),
        .entry_req(entry_req), .entry_in(entry_in),
        .entry_done_r(entry_done_r), .entry_fail_r(entry_fail_r),
        .fail_why_r(fail_why_r), .tmr_load(tmr_load), .tmr_val(tmr_val),
        .tmr_run(tmr_run), .tsc_inc(tsc_inc), .tsc_val(tsc_val),
        .tmr_count_r(tmr_count_r), .tmr_expired_r(tmr_expired_r),
        .vm_exit(vm_exit), .long_mode_active_flag(lma),
        .lmg_ctl_r(lmg_ctl_r), .smm_mon_wr(smm_mon_wr),
        .smm_mon_wbit(smm_mon_wbit), .smm_mon_bit2_r(smm_mon_bit2_r),
        .virt_leave_instr(leave), .smi_unblock_r(smi_unblock_r),
        .fw_req(fw_req), .fw_exit_info(fw_exit_info),
        .fw_refuse_r(fw_refuse_r));

    // second bank: bit 55 clear, no secondary or free field writes
    vccc_top #(.BASIC_TRUE_CTLS(1'b0), .PRIM_SEC_OK(1'b0),
        .CONTROL_FIELD_WRITE_INSTR_ALL(1'b0)) u_legacy (
        .clk_sys(clk_sys), .rst_n(rst_n), .rd_req(rd_req), .wr_req(wr_req),
        .rd_index(rd_index), .in_smm(in_smm), .smbase_val(smbase_val),
        .rd_data_r(), .rd_ack_r(lg_ack), .rd_fault_r(lg_flt),
        .entry_req(entry_req), .entry_in(entry_in), .entry_done_r(),
        .entry_fail_r(), .fail_why_r(lg_why), .tmr_load(tmr_load),
        .tmr_val(tmr_val), .tmr_run(tmr_run), .tsc_inc(tsc_inc),
        .tsc_val(tsc_val), .tmr_count_r(), .tmr_expired_r(),
        .vm_exit(vm_exit), .long_mode_active_flag(lma), .lmg_ctl_r(),
        .smm_mon_wr(smm_mon_wr), .smm_mon_wbit(smm_mon_wbit),
        .smm_mon_bit2_r(), .virt_leave_instr(leave), .smi_unblock_r(),
        .fw_req(fw_req), .fw_exit_info(fw_exit_info), .fw_refuse_r(lg_fw));

    // free-running core clock
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // one comparison, counted; case inequality so an unknown never matches a known bit
    task automatic chk(input logic [63:0] got, input logic [63:0] exp,
                       input string what);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got,
                     exp);
        end
    endtask : chk

    // register access: one-cycle request, answer checked one cycle later
    task automatic rd(input logic [31:0] idx, input logic wr,
                      input logic flt, input logic [63:0] exp);
        rd_req <= ~wr;
        wr_req <= wr;
        rd_index <= idx;
        @(posedge clk_sys);
        rd_req <= 1'b0;
        wr_req <= 1'b0;
        #1;
        chk({62'h0, rd_ack_r, rd_fault_r}, {62'h0, 1'b1, flt}, "answer");
        chk(rd_data_r, exp, "read data");
        if (idx inside {`VCCC_SEC_CAP_IDX, `VCCC_TEXIT_CAP_IDX,
                        `VCCC_TENTRY_CAP_IDX})
            chk({62'h0, lg_ack, lg_flt}, 64'h3, "legacy");
        @(posedge clk_sys);
    endtask : rd

    // entry check request; expected reasons are {sec,exits,entries,act}
    task automatic ent(input logic a, input logic [31:0] s, x, n,
                       input vccc_pkg::vccc_activity_t act,
                       input logic [3:0] why);
        entry_req <= 1'b1;
        entry_in <= '{act_sec: a, sec_ctl: s, exit_ctl: x, entry_ctl: n,
                       activity: act};
        @(posedge clk_sys);
        entry_req <= 1'b0;
        #1;
        chk({62'h0, entry_done_r, entry_fail_r}, {62'h0, 1'b1, |why},
            "entry verdict");
        chk({60'h0, fail_why_r}, {60'h0, why}, "entry reasons");
        @(posedge clk_sys);
    endtask : ent

    // one cycle of timer stimulus, then the count seen after the next edge
    task automatic tick(input logic inc, input logic [63:0] tv,
                        input logic [31:0] exp, input logic exp_x);
        tsc_inc <= inc;
        tsc_val <= tv;
        @(posedge clk_sys);
        tsc_inc <= 1'b0;
        #1;
        chk({31'h0, tmr_expired_r, tmr_count_r}, {31'h0, exp_x, exp},
            "timer");
        @(posedge clk_sys);
    endtask : tick

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict

    // hang guard: far beyond the length of the sequence below
    initial begin
        #1000000;
        err_count++;
        $display("[FAIL] %0t run did not finish", $time);
        print_verdict();
    end

    initial begin
        {rd_req, wr_req, in_smm, entry_req, tmr_load, tmr_run} = '0;
        {tsc_inc, vm_exit, lma, smm_mon_wr, smm_mon_wbit, leave} = '0;
        {fw_req, fw_exit_info, rst_n} = '0;
        rd_index = '0;
        tmr_val = '0;
        tsc_val = '0;
        entry_in = '0;
        smbase_val = 64'h0123_4567_89ab_cdef;
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        #1;
        chk({63'h0, rd_ack_r}, 64'h0, "idle after reset");
        @(posedge clk_sys);
        // capability reads, refusals and write immunity
        rd(`VCCC_SEC_CAP_IDX, 1'b0, 1'b0,
           {SEC_A1, 32'h0});
        rd(`VCCC_EXIT_CAP_IDX, 1'b0, 1'b0,
           {EXIT_A1, `VCCC_EXIT_DEF1_MASK});
        rd(`VCCC_ENTRY_CAP_IDX, 1'b0, 1'b0,
           {ENTRY_A1, `VCCC_ENTRY_DEF1_MASK});
        rd(`VCCC_TEXIT_CAP_IDX, 1'b0, 1'b0, {EXIT_A1, EXIT_TA0});
        rd(`VCCC_TENTRY_CAP_IDX, 1'b0, 1'b0,
           {ENTRY_A1, ENTRY_TA0});
        rd(`VCCC_MISC_CAP_IDX, 1'b0, 1'b0,
           MISC_EXP);
        rd(`VCCC_MISC_CAP_IDX, 1'b1, 1'b1, 64'h0);
        rd(`VCCC_MISC_CAP_IDX, 1'b0, 1'b0, MISC_EXP);
        rd(32'h0000_0486, 1'b0, 1'b1, 64'h0);
        rd(`VCCC_SMM_BASE_IDX, 1'b0, 1'b1, 64'h0);
        in_smm <= 1'b1;
        rd(`VCCC_SMM_BASE_IDX, 1'b0, 1'b0, smbase_val);
        in_smm <= 1'b0;
        $display("register reads done");
        // entry checks against the true reports
        ent(1'b0, 32'h0, EXIT_TA0, ENTRY_TA0, vccc_pkg::VCCC_ACT_ACTIVE,
            4'h0);
        chk({60'h0, lg_why}, 64'h6, "legacy default-one");
        ent(1'b0, 32'h0, 32'h0, ENTRY_TA0, vccc_pkg::VCCC_ACT_ACTIVE,
            4'h4);
        ent(1'b0, 32'h0, 32'h0040_0004, ENTRY_TA0, vccc_pkg::VCCC_ACT_ACTIVE,
            4'h4);
        ent(1'b0, 32'h0, EXIT_TA0, 32'h0001_0200, vccc_pkg::VCCC_ACT_ACTIVE,
            4'h2);
        ent(1'b0, 32'h0, EXIT_TA0, 32'h0, vccc_pkg::VCCC_ACT_ACTIVE,
            4'h2);
        ent(1'b1, 32'h100, EXIT_TA0, ENTRY_TA0, vccc_pkg::VCCC_ACT_ACTIVE,
            4'h8);
        ent(1'b0, 32'h100, EXIT_TA0, ENTRY_TA0, vccc_pkg::VCCC_ACT_ACTIVE,
            4'h0);
        ent(1'b1, 32'h80, EXIT_TA0, ENTRY_TA0, vccc_pkg::VCCC_ACT_ACTIVE,
            4'h0);
        for (int i = 1; i < 4; i++) begin
            ent(1'b0, 32'h0, EXIT_TA0, ENTRY_TA0,
                vccc_pkg::vccc_activity_t'(i),
                {3'h0, ~ACT_SUP[i-1]});
        end
        $display("entry checks done");
        // preemption timer: only an increment that flips bit 5 counts
        tmr_load <= 1'b1;
        tmr_val <= 32'h0000_0002;
        tmr_run <= 1'b1;
        @(posedge clk_sys);
        tmr_load <= 1'b0;
        tick(1'b1, 64'h20, 32'h1, 1'b0);
        tick(1'b1, 64'h21, 32'h1, 1'b0);
        tick(1'b0, 64'h00, 32'h1, 1'b0);
        tick(1'b1, 64'h20, 32'h0, 1'b1);
        $display("timer done");
        // exit copy of long mode, monitor bit and field writes
        lma <= 1'b1;
        vm_exit <= 1'b1;
        smm_mon_wr <= 1'b1;
        smm_mon_wbit <= 1'b1;
        fw_req <= 1'b1;
        fw_exit_info <= 1'b1;
        @(posedge clk_sys);
        {vm_exit, smm_mon_wr, fw_req} <= 3'h0;
        leave <= 1'b1;
        #1;
        chk({61'h0, lmg_ctl_r, smm_mon_bit2_r, fw_refuse_r}, 64'h6,
            "exit and monitor");
        chk({63'h0, lg_fw}, 64'h1, "legacy field write");
        // leave stays high; bit 2 cleared while the old value still rules
        @(posedge clk_sys);
        smm_mon_wr <= 1'b1;
        smm_mon_wbit <= 1'b0;
        #1;
        chk({63'h0, smi_unblock_r}, 64'h0, "blocked unblock");
        @(posedge clk_sys);
        smm_mon_wr <= 1'b0;
        #1;
        chk({63'h0, smi_unblock_r}, 64'h0, "old bit rules");
        @(posedge clk_sys);
        leave <= 1'b0;
        #1;
        chk({63'h0, smi_unblock_r}, 64'h1, "unblock pulse");
        $display("exit and monitor done");
        print_verdict();
    end
endmodule : vccc_top_tb
